// *** core/uhcr_control.sv ***
// Host controller control register with functional state, frame start and list enables.
`timescale 1ns/1ns
module uhcr_control #(
	parameter int unsigned SOF_DELAY_CYCLES = uhcr_pkg::SOF_DELAY_CYC,
	parameter int unsigned FRAME_CYCLES = uhcr_pkg::FRAME_CYC
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic soft_reset,
	input wire logic resume_detected,
	input wire logic downstream_resume,
	input wire logic status_irq_event,
	input wire logic iso_ed_found,
	input wire logic control_pending,
	input wire logic bulk_pending,
	input wire logic ed_served,
	input wire logic ed_served_ctrl,
	output logic [1:0] host_functional_state,
	output logic host_irq,
	output logic smi_irq,
	output logic remote_wakeup,
	output logic root_hub_reset,
	output logic port_reset_drive,
	output logic sof_pulse,
	output logic frame_start_flag,
	output logic periodic_go,
	output logic periodic_halt,
	output logic serve_control,
	output logic serve_bulk
);
	typedef enum logic [1:0] {SOF_IDLE, SOF_WAIT, SOF_RUN} uhcr_sof_t;

	// Stored fields of the control word.
	logic [1:0] fs;
	logic remote_wake_enable;
	logic remote_wake_connected;
	logic interrupt_route_select;
	logic bulk_list_on;
	logic control_list_on;
	logic isochronous_on;
	logic periodic_list_on;
	logic [1:0] ctrl_bulk_ratio;

	logic [1:0] next_fs;
	logic next_remote_wake_enable;
	logic next_remote_wake_connected;
	logic next_interrupt_route_select;
	logic next_bulk_list_on;
	logic next_control_list_on;
	logic next_isochronous_on;
	logic next_periodic_list_on;
	logic [1:0] next_ctrl_bulk_ratio;

	logic reg_hit;
	logic wr_hit;
	logic rd_hit;
	logic hw_resume;
	logic [31:0] ctrl_word;

	// Frame sequencer.
	uhcr_sof_t sof_state;
	uhcr_sof_t next_sof_state;
	logic [23:0] sof_count;
	logic [23:0] next_sof_count;
	logic is_oper;
	logic op_entry;
	logic delay_done;
	logic frame_done;
	logic sof_now;

	// Enables captured at the last frame start.
	logic frame_periodic;
	logic frame_iso;
	logic frame_control;
	logic frame_bulk;
	logic halt_set;
	logic next_periodic_halt;
	logic port_reset_hold;

	uhcr_sched_if sched ();

	// Address decode; only the control word answers in this block.
	assign reg_hit = reg_addr == uhcr_pkg::CTRL_OFFSET;
	assign wr_hit = reg_write & reg_hit;
	assign rd_hit = reg_read & reg_hit;

	// Reserved bits are neither stored nor returned, so a careless write is harmless.
	assign ctrl_word = {21'h000000,
		remote_wake_enable,
		remote_wake_connected,
		interrupt_route_select,
		fs,
		bulk_list_on,
		control_list_on,
		isochronous_on,
		periodic_list_on,
		ctrl_bulk_ratio};

	// Hardware may only step from suspend to resume; any other state is software's.
	assign hw_resume = (fs == uhcr_pkg::STATE_SUSPEND) & downstream_resume;

	// Software reset forces suspend and wins over a write in the same cycle.
	assign next_fs = soft_reset ? uhcr_pkg::STATE_SUSPEND :
		wr_hit ? reg_wdata[uhcr_pkg::STATE_LSB +: 2] :
		hw_resume ? uhcr_pkg::STATE_RESUME : fs;

	// Ownership and wake-connected survive a software reset.
	assign next_remote_wake_connected = wr_hit ?
		reg_wdata[uhcr_pkg::WAKE_CONN_BIT] : remote_wake_connected;
	assign next_interrupt_route_select = wr_hit ?
		reg_wdata[uhcr_pkg::ROUTE_BIT] : interrupt_route_select;

	// The remaining fields return to zero on a software reset.
	assign next_remote_wake_enable = soft_reset ? 1'b0 :
		wr_hit ? reg_wdata[uhcr_pkg::WAKE_EN_BIT] : remote_wake_enable;
	assign next_bulk_list_on = soft_reset ? 1'b0 :
		wr_hit ? reg_wdata[uhcr_pkg::BULK_BIT] : bulk_list_on;
	assign next_control_list_on = soft_reset ? 1'b0 :
		wr_hit ? reg_wdata[uhcr_pkg::CONTROL_BIT] : control_list_on;
	assign next_isochronous_on = soft_reset ? 1'b0 :
		wr_hit ? reg_wdata[uhcr_pkg::ISO_BIT] : isochronous_on;
	assign next_periodic_list_on = soft_reset ? 1'b0 :
		wr_hit ? reg_wdata[uhcr_pkg::PERIODIC_BIT] : periodic_list_on;
	assign next_ctrl_bulk_ratio = soft_reset ? 2'h0 :
		wr_hit ? reg_wdata[uhcr_pkg::RATIO_LSB +: 2] : ctrl_bulk_ratio;

	// Control word storage; a hardware reset clears every field.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fs <= uhcr_pkg::STATE_RESET;
			remote_wake_enable <= 1'b0;
			remote_wake_connected <= 1'b0;
			interrupt_route_select <= 1'b0;
			bulk_list_on <= 1'b0;
			control_list_on <= 1'b0;
			isochronous_on <= 1'b0;
			periodic_list_on <= 1'b0;
			ctrl_bulk_ratio <= 2'h0;
		end else begin
			fs <= next_fs;
			remote_wake_enable <= next_remote_wake_enable;
			remote_wake_connected <= next_remote_wake_connected;
			interrupt_route_select <= next_interrupt_route_select;
			bulk_list_on <= next_bulk_list_on;
			control_list_on <= next_control_list_on;
			isochronous_on <= next_isochronous_on;
			periodic_list_on <= next_periodic_list_on;
			ctrl_bulk_ratio <= next_ctrl_bulk_ratio;
		end
	end

	// Frame timing: first start after the entry delay, then one per frame period.
	assign is_oper = fs == uhcr_pkg::STATE_OPERATIONAL;
	assign op_entry = (next_fs == uhcr_pkg::STATE_OPERATIONAL) & ~is_oper;
	assign delay_done = sof_count == 24'(SOF_DELAY_CYCLES - 1);
	assign frame_done = sof_count == 24'(FRAME_CYCLES - 1);
	assign sof_now = is_oper & (((sof_state == SOF_WAIT) & delay_done) |
		((sof_state == SOF_RUN) & frame_done));

	// Next state of the frame sequencer; leaving operational stops frames at once.
	always_comb begin
		next_sof_state = sof_state;
		next_sof_count = sof_count + 24'h1;
		unique case (sof_state)
			SOF_IDLE: begin
				next_sof_count = 24'h0;
			end
			SOF_WAIT: begin
				if (delay_done) begin
					next_sof_state = SOF_RUN;
					next_sof_count = 24'h0;
				end
			end
			SOF_RUN: begin
				if (frame_done) begin
					next_sof_count = 24'h0;
				end
			end
		endcase
		if (op_entry) begin
			next_sof_state = SOF_WAIT;
			next_sof_count = 24'h0;
		end else if (next_fs != uhcr_pkg::STATE_OPERATIONAL) begin
			next_sof_state = SOF_IDLE;
			next_sof_count = 24'h0;
		end
	end

	// Sequencer registers.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sof_state <= SOF_IDLE;
			sof_count <= 24'h0;
		end else begin
			sof_state <= next_sof_state;
			sof_count <= next_sof_count;
		end
	end

	// Enables sampled at each frame start: a set counts from the next frame,
	// a clear stops the list no later than the next frame start.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			frame_periodic <= 1'b0;
			frame_iso <= 1'b0;
			frame_control <= 1'b0;
			frame_bulk <= 1'b0;
		end else if (!is_oper) begin
			frame_periodic <= 1'b0;
			frame_iso <= 1'b0;
			frame_control <= 1'b0;
			frame_bulk <= 1'b0;
		end else if (sof_now) begin
			frame_periodic <= periodic_list_on;
			frame_iso <= isochronous_on;
			frame_control <= control_list_on;
			frame_bulk <= bulk_list_on;
		end
	end

	// A disabled isochronous descriptor ends the periodic list for this frame.
	assign halt_set = periodic_go & iso_ed_found & ~frame_iso;
	assign next_periodic_halt = halt_set | (periodic_halt & ~sof_now & is_oper);

	// Control and bulk also follow the live bit, since the list is checked
	// each time the controller wants it; an early stop is still within bounds.
	assign sched.ratio = ctrl_bulk_ratio;
	assign sched.ctrl_on = frame_control & control_list_on;
	assign sched.bulk_on = frame_bulk & bulk_list_on;
	assign sched.ctrl_pending = control_pending;
	assign sched.bulk_pending = bulk_pending;
	assign sched.served = ed_served;
	assign sched.served_ctrl = ed_served_ctrl;

	uhcr_ratio_arb u_ratio_arb (
		.clock(clock),
		.reset_n(reset_n),
		.sched(sched)
	);

	// Port reset follows a hardware reset until software leaves the reset state; hub reset drops at the first clock after reset.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			port_reset_hold <= 1'b1;
		end else if (fs != uhcr_pkg::STATE_RESET) begin
			port_reset_hold <= 1'b0;
		end
	end

	// Registered outputs toward the system, the root hub and the list engine.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0000_0000;
			host_functional_state <= uhcr_pkg::STATE_RESET;
			host_irq <= 1'b0;
			smi_irq <= 1'b0;
			remote_wakeup <= 1'b0;
			root_hub_reset <= 1'b1;
			port_reset_drive <= 1'b1;
			sof_pulse <= 1'b0;
			frame_start_flag <= 1'b0;
			periodic_go <= 1'b0;
			periodic_halt <= 1'b0;
			serve_control <= 1'b0;
			serve_bulk <= 1'b0;
		end else begin
			reg_rdata <= rd_hit ? ctrl_word : 32'h0000_0000;
			host_functional_state <= fs;
			host_irq <= status_irq_event & ~interrupt_route_select;
			smi_irq <= status_irq_event & interrupt_route_select;
			remote_wakeup <= remote_wake_enable & resume_detected;
			root_hub_reset <= 1'b0;
			port_reset_drive <= port_reset_hold & (fs == uhcr_pkg::STATE_RESET);
			sof_pulse <= sof_now;
			frame_start_flag <= sof_now;
			periodic_go <= frame_periodic & ~next_periodic_halt;
			periodic_halt <= next_periodic_halt;
			serve_control <= sched.pick_ctrl;
			serve_bulk <= sched.pick_bulk;
		end
	end
endmodule

// *** core/uhcr_pkg.sv ***
// Package with the offsets, field layout, encodings and timing of the host control register.
package uhcr_pkg;
	// Register offset from the operational register base.
	localparam logic [7:0] CTRL_OFFSET = 8'h04;
	// Field positions inside the control word.
	localparam int RATIO_LSB = 0;
	localparam int PERIODIC_BIT = 2;
	localparam int ISO_BIT = 3;
	localparam int CONTROL_BIT = 4;
	localparam int BULK_BIT = 5;
	localparam int STATE_LSB = 6;
	localparam int ROUTE_BIT = 8;
	localparam int WAKE_CONN_BIT = 9;
	localparam int WAKE_EN_BIT = 10;
	// Value after a hardware reset.
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// Functional state encodings.
	localparam logic [1:0] STATE_RESET = 2'h0;
	localparam logic [1:0] STATE_RESUME = 2'h1;
	localparam logic [1:0] STATE_OPERATIONAL = 2'h2;
	localparam logic [1:0] STATE_SUSPEND = 2'h3;
	// Timing at the 10 MHz core clock.
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int SOF_DELAY_NS = 1000000;
	localparam int FRAME_NS = 1000000;
	localparam int SOF_DELAY_CYC = (SOF_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int FRAME_CYC = FRAME_NS / CLOCK_PERIOD_NS;
	// Served-control counter width; ratio 4:1 needs a count up to 4.
	localparam int COUNT_W = 3;
	localparam logic [2:0] COUNT_RESET = 3'h0;
endpackage

// *** core/uhcr_sched_if.sv ***
// Interface between the control register and the control/bulk ratio arbiter.
`timescale 1ns/1ns
interface uhcr_sched_if;
	logic [1:0] ratio;
	logic ctrl_on;
	logic bulk_on;
	logic ctrl_pending;
	logic bulk_pending;
	logic served;
	logic served_ctrl;
	logic pick_ctrl;
	logic pick_bulk;
	modport ctl (
		output ratio, ctrl_on, bulk_on, ctrl_pending, bulk_pending, served, served_ctrl,
		input pick_ctrl, pick_bulk
	);
	modport arb (
		input ratio, ctrl_on, bulk_on, ctrl_pending, bulk_pending, served, served_ctrl,
		output pick_ctrl, pick_bulk
	);
endinterface

// *** core/uhcr_ratio_arb.sv ***
// Control versus bulk service ratio arbiter with a count kept across frames.
`timescale 1ns/1ns
module uhcr_ratio_arb (
	input wire logic clock,
	input wire logic reset_n,
	uhcr_sched_if.arb sched
);
	logic [uhcr_pkg::COUNT_W-1:0] served_count;
	logic [uhcr_pkg::COUNT_W-1:0] next_served_count;
	logic ctrl_ready;
	logic bulk_ready;
	logic under_ratio;

	// A control descriptor is preferred until the count passes the ratio.
	assign ctrl_ready = sched.ctrl_on & sched.ctrl_pending;
	assign bulk_ready = sched.bulk_on & sched.bulk_pending;
	assign under_ratio = served_count <= {1'b0, sched.ratio};
	assign sched.pick_ctrl = ctrl_ready & (under_ratio | ~bulk_ready);
	assign sched.pick_bulk = bulk_ready & ~sched.pick_ctrl;

	// Count saturates so a long run of control traffic cannot wrap it.
	assign next_served_count = !sched.served ? served_count :
		!sched.served_ctrl ? uhcr_pkg::COUNT_RESET :
		under_ratio ? served_count + 3'h1 : served_count;

	// Only a hardware reset or a served bulk descriptor clears the count; frame boundaries leave it alone.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			served_count <= uhcr_pkg::COUNT_RESET;
		end else begin
			served_count <= next_served_count;
		end
	end
endmodule

// *** tb/uhcr_control_assertions.sv ***
// Port checker for the host control register.
`timescale 1ns/1ns
module uhcr_control_assertions #(
	parameter int unsigned SOF_DELAY_CYCLES = 20,
	parameter int unsigned FRAME_CYCLES = 16
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic soft_reset,
	input wire logic resume_detected,
	input wire logic downstream_resume,
	input wire logic status_irq_event,
	input wire logic [1:0] host_functional_state,
	input wire logic host_irq,
	input wire logic smi_irq,
	input wire logic remote_wakeup,
	input wire logic root_hub_reset,
	input wire logic sof_pulse,
	input wire logic frame_start_flag,
	input wire logic serve_control,
	input wire logic serve_bulk
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Suspend that nothing disturbed, so the live state is still suspend.
	sequence s_quiet_suspend;
		host_functional_state == uhcr_pkg::STATE_SUSPEND && !$past(reg_write)
			&& !$past(soft_reset) && !$past(downstream_resume);
	endsequence
	sequence s_resume_req;
		downstream_resume && !reg_write && !soft_reset;
	endsequence
	a_resume_move: assert property (s_quiet_suspend ##0 s_resume_req |-> ##2
		host_functional_state == uhcr_pkg::STATE_RESUME) else $error("resume not taken");
	a_soft_suspend: assert property (soft_reset |=> ##1
		host_functional_state == uhcr_pkg::STATE_SUSPEND) else $error("soft reset state");
	a_irq_follow: assert property ((host_irq || smi_irq) == $past(status_irq_event))
		else $error("interrupt lost");
	a_route_excl: assert property (!(host_irq && smi_irq))
		else $error("both interrupts");
	a_wake_off: assert property (!resume_detected [*2] |-> !remote_wakeup)
		else $error("wake-up without resume");
	a_rsvd_zero: assert property (reg_rdata[31:11] == 21'h0)
		else $error("reserved bits set");
	a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("read data without read");
	a_sof_pair: assert property (sof_pulse == frame_start_flag)
		else $error("flag and frame start differ");
	a_sof_gap: assert property (sof_pulse |=> !sof_pulse [*8])
		else $error("frame starts too close");
	a_hub_pulse: assert property (root_hub_reset |=> !root_hub_reset)
		else $error("hub reset too long");
	a_serve_excl: assert property (!(serve_control && serve_bulk))
		else $error("both lists served");
endmodule
bind uhcr_control uhcr_control_assertions #(
	.SOF_DELAY_CYCLES(SOF_DELAY_CYCLES),
	.FRAME_CYCLES(FRAME_CYCLES)
) u_chk (.*);

// *** tb/test_usb_host_control_register.sv ***
// Self-checking bench for the host control register.
`timescale 1ns/1ns
module test_usb_host_control_register;
	localparam int unsigned SOF_D = 20;
	localparam int unsigned FRAME_D = 16;
	localparam logic [7:0] OFF = uhcr_pkg::CTRL_OFFSET;
	logic clock, reset_n, reg_write, reg_read, soft_reset, resume_detected, downstream_resume;
	logic status_irq_event, iso_ed_found, control_pending, bulk_pending, ed_served;
	logic ed_served_ctrl, host_irq, smi_irq, remote_wakeup, root_hub_reset, port_reset_drive;
	logic sof_pulse, frame_start_flag, periodic_go, periodic_halt, serve_control, serve_bulk;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seen;
	logic [1:0] host_functional_state;
	int errors, checks_done, n;
	uhcr_control #(.SOF_DELAY_CYCLES(SOF_D), .FRAME_CYCLES(FRAME_D)) dut (.*);
	// Core clock at 10 MHz.
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic summarize();
		if (errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Strobes rise on a falling edge, so the rising edge between takes them cleanly.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(negedge clock);
		reg_write = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		reg_addr = a;
		reg_read = 1'b1;
		@(negedge clock);
		reg_read = 1'b0;
		seen = reg_rdata;
	endtask
	// Counts cycles to the next frame start; always steps once so a pulse is not recounted.
	task automatic wait_sof();
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (sof_pulse !== 1'b1 && n < 200);
		if (n >= 200) begin
			errors++;
			summarize();
		end
	endtask
	// Reports one served descriptor; the arbiter's choice shows two edges later.
	task automatic serve(input logic c);
		ed_served = 1'b1;
		ed_served_ctrl = c;
		@(negedge clock);
		ed_served = 1'b0;
		@(negedge clock);
	endtask
	// Main sequence of register and frame scenarios.
	initial begin
		errors = 0;
		checks_done = 0;
		reset_n = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		{reg_write, reg_read, soft_reset, resume_detected, downstream_resume} = 5'h0;
		{status_irq_event, iso_ed_found, control_pending, bulk_pending} = 4'h0;
		{ed_served, ed_served_ctrl} = 2'h0;
		repeat (12) @(negedge clock);
		chk("port_reset_drive", port_reset_drive, 32'h1);
		reset_n = 1'b1;
		rd(OFF);
		chk("reset_word", seen, uhcr_pkg::CTRL_RESET);
		chk("reset_state", host_functional_state, uhcr_pkg::STATE_RESET);
		chk("port_reset_held", port_reset_drive, 32'h1);
		wr(OFF, 32'h0000_073f);
		rd(OFF);
		chk("full_word", seen, 32'h0000_073f);
		// A stray address must neither answer nor disturb the register.
		wr(8'h08, 32'h0);
		rd(8'h08);
		chk("other_addr", seen, 32'h0);
		rd(OFF);
		chk("kept_word", seen, 32'h0000_073f);
		status_irq_event = 1'b1;
		resume_detected = 1'b1;
		@(negedge clock);
		chk("smi_irq", smi_irq, 32'h1);
		chk("host_irq_off", host_irq, 32'h0);
		chk("wakeup_on", remote_wakeup, 32'h1);
		// Route and wake enable cleared: the interrupt moves and wake-up drops.
		wr(OFF, 32'h0000_023f);
		@(negedge clock);
		chk("host_irq", host_irq, 32'h1);
		chk("wakeup_off", remote_wakeup, 32'h0);
		status_irq_event = 1'b0;
		resume_detected = 1'b0;
		wr(OFF, 32'h0000_073f);
		@(negedge clock);
		soft_reset = 1'b1;
		@(negedge clock);
		soft_reset = 1'b0;
		rd(OFF);
		chk("soft_word", seen, 32'h0000_03c0);
		downstream_resume = 1'b1;
		repeat (2) @(negedge clock);
		chk("resume_state", host_functional_state, uhcr_pkg::STATE_RESUME);
		downstream_resume = 1'b0;
		reset_n = 1'b0;
		@(negedge clock);
		reset_n = 1'b1;
		rd(OFF);
		chk("hw_reset_word", seen, 32'h0);
		// Operational with periodic, control and bulk lists on, isochronous off.
		wr(OFF, 32'h0000_00b4);
		wait_sof();
		chk("sof_delay", n, SOF_D);
		chk("port_reset_off", port_reset_drive, 32'h0);
		chk("sof_flag", frame_start_flag, 32'h1);
		wait_sof();
		chk("frame_period", n, FRAME_D);
		repeat (2) @(negedge clock);
		chk("periodic_go", periodic_go, 32'h1);
		iso_ed_found = 1'b1;
		@(negedge clock);
		iso_ed_found = 1'b0;
		@(negedge clock);
		chk("periodic_halt", periodic_halt, 32'h1);
		control_pending = 1'b1;
		downstream_resume = 1'b1;
		wait_sof();
		repeat (2) @(negedge clock);
		chk("serve_control", serve_control, 32'h1);
		chk("no_hw_change", host_functional_state, uhcr_pkg::STATE_OPERATIONAL);
		// Control list turned off while bulk waits: bulk is served instead.
		bulk_pending = 1'b1;
		wr(OFF, 32'h0000_00a4);
		wait_sof();
		repeat (2) @(negedge clock);
		chk("serve_bulk", serve_bulk, 32'h1);
		chk("control_stopped", serve_control, 32'h0);
		// Control list re-enabled with ratio 2:1; the served count must survive a frame.
		wr(OFF, 32'h0000_00b5);
		wait_sof();
		@(negedge clock);
		chk("ratio_first", serve_control, 32'h1);
		serve(1'b1);
		chk("ratio_second", serve_control, 32'h1);
		wait_sof();
		serve(1'b1);
		chk("ratio_switch", serve_bulk, 32'h1);
		chk("ratio_no_ctrl", serve_control, 32'h0);
		serve(1'b0);
		chk("ratio_restart", serve_control, 32'h1);
		// Isochronous enable set mid-frame is not honoured until the next frame.
		wait_sof();
		wr(OFF, 32'h0000_00bd);
		iso_ed_found = 1'b1;
		@(negedge clock);
		iso_ed_found = 1'b0;
		@(negedge clock);
		chk("iso_late", periodic_halt, 32'h1);
		wait_sof();
		@(negedge clock);
		iso_ed_found = 1'b1;
		@(negedge clock);
		iso_ed_found = 1'b0;
		@(negedge clock);
		chk("iso_next_frame", periodic_halt, 32'h0);
		chk("periodic_runs", periodic_go, 32'h1);
		summarize();
	end
endmodule
